// ### verilog/mbw_pkg.sv
// package: constants and types for the boot and runtime watchdog
package mbw_pkg;
   // time base
   localparam int unsigned CLK_HZ       = 40000000;
   localparam int unsigned TICK_MS      = 1;
   localparam int unsigned TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
   // register byte offsets
   localparam logic [7:0] OFS_BOOT_CFG  = 8'h00;
   localparam logic [7:0] OFS_RT_CFG    = 8'h04;
   localparam logic [7:0] OFS_STG_CFG   = 8'h08;
   localparam logic [7:0] OFS_TRIGGER   = 8'h0C;
   localparam logic [7:0] OFS_STATUS    = 8'h10;
   localparam logic [7:0] OFS_CONTROL   = 8'h14;
   // reset values
   localparam logic [31:0] RST_BOOT_CFG = 32'h0000_0000;
   localparam logic [31:0] RST_RT_CFG   = 32'h0000_0000;
   localparam logic [31:0] RST_STG_CFG  = 32'h0000_0001;
   // axi responses
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   // boot_cfg fields
   localparam int unsigned BOOT_TO_LSB  = 0;
   localparam int unsigned BOOT_PAUSE_BIT = 4;
   // rt_cfg fields
   localparam int unsigned RT_MODE_LSB  = 0;
   localparam int unsigned RT_DELAY_LSB = 4;
   localparam int unsigned RT_ACPI_BIT  = 8;
   // stg_cfg fields: per stage 4 bits timeout, 2 bits event
   localparam int unsigned STG_TO_LSB   = 0;
   localparam int unsigned STG_EV_LSB   = 4;
   localparam int unsigned STG_STRIDE   = 8;
   // control bits (self clearing strobes / levels)
   localparam int unsigned CTL_POST_BIT  = 0;
   localparam int unsigned CTL_WAIT_BIT  = 1;
   localparam int unsigned CTL_OSARM_BIT = 2;

   typedef enum logic [1:0] {
      MBW_MODE_OFF    = 2'b00,
      MBW_MODE_ONCE   = 2'b01,
      MBW_MODE_SINGLE = 2'b10,
      MBW_MODE_REPEAT = 2'b11
   } mbw_mode_e;

   typedef enum logic [1:0] {
      MBW_EV_NONE  = 2'b00,
      MBW_EV_ACPI  = 2'b01,
      MBW_EV_RESET = 2'b10,
      MBW_EV_PWRB  = 2'b11
   } mbw_event_e;

   typedef enum logic [2:0] {
      MBW_RT_IDLE  = 3'b000,
      MBW_RT_DELAY = 3'b001,
      MBW_RT_RUN   = 3'b010,
      MBW_RT_DONE  = 3'b011
   } mbw_rt_state_e;

   typedef struct packed {
      logic sys_reset;
      logic pwr_button;
      logic acpi_overtemp;
      logic acpi_fatal;
   } mbw_action_s;

   typedef struct packed {
      logic        valid;
      logic [7:0]  addr;
   } mbw_addr_s;

   // millisecond tables; index 0 is the disabled/none entry for boot and delay, 1 s for stages
   function automatic logic [20:0] mbw_boot_ms(input logic [3:0] s);
      unique case (s)
         4'h1:    mbw_boot_ms = 21'd30000;
         4'h2:    mbw_boot_ms = 21'd60000;
         4'h3:    mbw_boot_ms = 21'd120000;
         4'h4:    mbw_boot_ms = 21'd300000;
         4'h5:    mbw_boot_ms = 21'd600000;
         4'h6:    mbw_boot_ms = 21'd1800000;
         default: mbw_boot_ms = 21'd0;
      endcase
   endfunction

   function automatic logic [20:0] mbw_delay_ms(input logic [3:0] s);
      unique case (s)
         4'h1:    mbw_delay_ms = 21'd10000;
         4'h2:    mbw_delay_ms = 21'd30000;
         4'h3:    mbw_delay_ms = 21'd60000;
         4'h4:    mbw_delay_ms = 21'd120000;
         4'h5:    mbw_delay_ms = 21'd300000;
         4'h6:    mbw_delay_ms = 21'd600000;
         4'h7:    mbw_delay_ms = 21'd1800000;
         default: mbw_delay_ms = 21'd0;
      endcase
   endfunction

   // stage timeouts: codes 0..9, out-of-range codes clamp to 1 s
   function automatic logic [20:0] mbw_stage_ms(input logic [3:0] s);
      unique case (s)
         4'h1:    mbw_stage_ms = 21'd2000;
         4'h2:    mbw_stage_ms = 21'd5000;
         4'h3:    mbw_stage_ms = 21'd10000;
         4'h4:    mbw_stage_ms = 21'd30000;
         4'h5:    mbw_stage_ms = 21'd60000;
         4'h6:    mbw_stage_ms = 21'd120000;
         4'h7:    mbw_stage_ms = 21'd300000;
         4'h8:    mbw_stage_ms = 21'd600000;
         4'h9:    mbw_stage_ms = 21'd1800000;
         default: mbw_stage_ms = 21'd1000;
      endcase
   endfunction
endpackage

// ### verilog/mbw_top.sv
// boot and runtime watchdog with axi4-lite register slave
// Summary of operation
// - boot timeout: off, 30s, 1/2/5/10/30 min
// - boot counts during self test, resets on expiry
// - pause option halts boot count during prompts
// - runtime modes: off, one-time, single, repeated
// - one-time mode disables on first trigger
// - single mode: each stage once, then off
// - repeated mode: last stage repeats until reset
// - runtime armed just before os boot
// - start delay: none, 10s .. 30 min
// - stage one action: acpi, reset or button
// - stages two, three: off, acpi, reset, button
// - stage one timeout: 1s .. 30 min
// - stages two, three use same timeouts
// - acpi action selects shutdown or restart
// - shutdown delivered as over-temperature notice
// - restart delivered as acpi fatal error
// - no nmi action exists
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mbw_top
   import mbw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   input  wire logic                 ce_i,
   // axi4-lite write
   input  wire logic                 s_awvalid_i,
   output logic                      s_awready_o,
   input  wire logic [7:0]           s_awaddr_i,
   input  wire logic                 s_wvalid_i,
   output logic                      s_wready_o,
   input  wire logic [31:0]          s_wdata_i,
   input  wire logic [3:0]           s_wstrb_i,
   output logic                      s_bvalid_o,
   input  wire logic                 s_bready_i,
   output logic [1:0]                s_bresp_o,
   // axi4-lite read
   input  wire logic                 s_arvalid_i,
   output logic                      s_arready_o,
   input  wire logic [7:0]           s_araddr_i,
   output logic                      s_rvalid_o,
   input  wire logic                 s_rready_i,
   output logic [31:0]               s_rdata_o,
   output logic [1:0]                s_rresp_o,
   // watchdog actions, one-cycle pulses
   output mbw_pkg::mbw_action_s      action_o
);
   import mbw_pkg::*;

   // axi write path: address and data captured independently
   mbw_addr_s   aw_reg;
   logic        w_have_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg;
   logic        bvalid_next;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   logic [31:0] boot_cfg_reg;
   logic [31:0] rt_cfg_reg;
   logic [31:0] stg_cfg_reg;
   logic        post_reg;
   logic        wait_reg;

   wire  do_write = aw_reg.valid && w_have_reg && !bvalid_reg;
   wire  wr_boot  = do_write && aw_reg.addr == OFS_BOOT_CFG;
   wire  wr_rt    = do_write && aw_reg.addr == OFS_RT_CFG;
   wire  wr_stg   = do_write && aw_reg.addr == OFS_STG_CFG;
   wire  wr_trig  = do_write && aw_reg.addr == OFS_TRIGGER;
   wire  wr_ctl   = do_write && aw_reg.addr == OFS_CONTROL;
   wire  wr_ok    = wr_boot | wr_rt | wr_stg | wr_trig | wr_ctl;
   wire  [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                         {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   assign s_awready_o = ce_i && !aw_reg.valid;
   assign s_wready_o  = ce_i && !w_have_reg;
   assign s_arready_o = ce_i && !rvalid_reg;
   assign s_bvalid_o  = bvalid_reg;
   assign s_bresp_o   = bresp_reg;
   assign s_rvalid_o  = rvalid_reg;
   assign s_rdata_o   = rdata_reg;
   assign s_rresp_o   = rresp_reg;
   assign bvalid_next = do_write || (bvalid_reg && !s_bready_i);

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   // millisecond tick from the free-running time base
   logic [31:0] pre_reg;
   wire         tick = (pre_reg == TICK_CYCLES - 1);

   // boot watchdog
   logic [20:0] boot_cnt_reg;
   wire  [3:0]  boot_sel   = boot_cfg_reg[BOOT_TO_LSB +: 4];
   wire  [20:0] boot_lim   = mbw_boot_ms(boot_sel);
   wire         boot_pause = boot_cfg_reg[BOOT_PAUSE_BIT] && wait_reg;
   wire         boot_run   = post_reg && boot_lim != 21'd0 && !boot_pause;
   wire         boot_exp   = boot_run && tick
                             && boot_cnt_reg == boot_lim - 21'd1;

   // runtime watchdog
   mbw_rt_state_e st_reg;
   logic [1:0]    stage_reg;
   logic [20:0]   cnt_reg;
   wire mbw_mode_e mode = mbw_mode_e'(rt_cfg_reg[RT_MODE_LSB +: 2]);
   wire  [3:0]  dly_sel  = rt_cfg_reg[RT_DELAY_LSB +: 4];
   wire  [20:0] dly_lim  = mbw_delay_ms(dly_sel);
   wire  [7:0]  stg_fld  = stg_cfg_reg[stage_reg * STG_STRIDE +: 8];
   wire  [20:0] stg_lim  = mbw_stage_ms(stg_fld[STG_TO_LSB +: 4]);
   wire  mbw_event_e ev  = mbw_event_e'(stg_fld[STG_EV_LSB +: 2]);
   // stage one never takes the none code; it falls back to acpi
   wire  mbw_event_e ev_eff = (stage_reg == 2'd0 && ev == MBW_EV_NONE)
                              ? MBW_EV_ACPI : ev;
   wire  [1:0]  nxt_stage = stage_reg + 2'd1;
   wire  [3:0]  nxt_ev    = 4'(stg_cfg_reg[nxt_stage * STG_STRIDE
                                           + STG_EV_LSB +: 2]);
   wire         has_next  = stage_reg != 2'd2 && nxt_ev != 4'h0;
   // arm comes from the latched word; the live bus may already be released
   wire         arm       = wr_ctl && wstrb_reg[0]
                            && wdata_reg[CTL_OSARM_BIT];
   wire         trig      = wr_trig && wstrb_reg[0]
                            && st_reg == MBW_RT_RUN;
   wire         stg_exp   = st_reg == MBW_RT_RUN && tick && !trig
                            && cnt_reg == stg_lim - 21'd1;
   wire         dly_done  = st_reg == MBW_RT_DELAY && tick
                            && cnt_reg >= dly_lim - 21'd1;

   // read decode; unmapped offsets answer with an error and zero data
   wire  [7:0]  rd_addr   = {s_araddr_i[7:2], 2'b00};
   wire  [31:0] status_w  = {25'h0, 3'(st_reg), stage_reg, 1'b0, post_reg};
   wire  [31:0] ctl_w     = {30'h0, wait_reg, post_reg};
   wire         rd_hit    = rd_addr == OFS_BOOT_CFG || rd_addr == OFS_RT_CFG
                            || rd_addr == OFS_STG_CFG
                            || rd_addr == OFS_TRIGGER
                            || rd_addr == OFS_STATUS
                            || rd_addr == OFS_CONTROL;
   wire  [31:0] rd_word   = rd_addr == OFS_BOOT_CFG ? boot_cfg_reg
                          : rd_addr == OFS_RT_CFG   ? rt_cfg_reg
                          : rd_addr == OFS_STG_CFG  ? stg_cfg_reg
                          : rd_addr == OFS_STATUS   ? status_w
                          : rd_addr == OFS_CONTROL  ? ctl_w
                          : 32'h0;

   // the only actions are acpi, reset and button; no nmi path exists
   mbw_action_s act_reg;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         aw_reg       <= '0;
         w_have_reg   <= 1'b0;
         wdata_reg    <= '0;
         wstrb_reg    <= '0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= RESP_OKAY;
         rvalid_reg   <= 1'b0;
         rdata_reg    <= '0;
         rresp_reg    <= RESP_OKAY;
      end else if (ce_i) begin
         if (s_awvalid_i && s_awready_o) begin
            aw_reg <= '{valid: 1'b1, addr: {s_awaddr_i[7:2], 2'b00}};
         end
         if (s_wvalid_i && s_wready_o) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_wdata_i;
            wstrb_reg  <= s_wstrb_i;
         end
         if (do_write) begin
            aw_reg.valid <= 1'b0;
            w_have_reg   <= 1'b0;
            bresp_reg    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         bvalid_reg <= bvalid_next;
         if (s_arvalid_i && s_arready_o) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_word;
         end else if (rvalid_reg && s_rready_i) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // configuration; control levels take effect only through byte lane 0
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         boot_cfg_reg <= RST_BOOT_CFG;
         rt_cfg_reg   <= RST_RT_CFG;
         stg_cfg_reg  <= RST_STG_CFG;
         post_reg     <= 1'b0;
         wait_reg     <= 1'b0;
      end else if (ce_i) begin
         if (wr_boot) boot_cfg_reg <= merge(boot_cfg_reg, wdata_reg, wmask);
         if (wr_rt)   rt_cfg_reg   <= merge(rt_cfg_reg, wdata_reg, wmask);
         if (wr_stg)  stg_cfg_reg  <= merge(stg_cfg_reg, wdata_reg, wmask);
         if (wr_ctl && wstrb_reg[0]) begin
            post_reg <= wdata_reg[CTL_POST_BIT];
            wait_reg <= wdata_reg[CTL_WAIT_BIT];
         end
      end
   end

   // prescaler; every timer advances only on its tick
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pre_reg <= '0;
      end else if (ce_i) begin
         pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
      end
   end

   // boot timer holds its count while paused; clearing post restarts it
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         boot_cnt_reg <= '0;
      end else if (ce_i) begin
         if (!post_reg) begin
            boot_cnt_reg <= '0;
         end else if (boot_run && tick) begin
            boot_cnt_reg <= boot_exp ? 21'd0 : boot_cnt_reg + 21'd1;
         end
      end
   end

   // runtime sequencing; reset of the system clears everything
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_reg    <= MBW_RT_IDLE;
         stage_reg <= 2'd0;
         cnt_reg   <= '0;
         act_reg   <= '0;
      end else if (ce_i) begin
         act_reg <= '0;
         if (boot_exp) begin
            act_reg.sys_reset <= 1'b1;
         end
         unique case (st_reg)
            MBW_RT_IDLE: begin
               if (arm && mode != MBW_MODE_OFF) begin
                  st_reg    <= MBW_RT_DELAY;
                  stage_reg <= 2'd0;
                  cnt_reg   <= '0;
               end
            end
            MBW_RT_DELAY: begin
               if (dly_done || dly_lim == 21'd0) begin
                  st_reg  <= MBW_RT_RUN;
                  cnt_reg <= '0;
               end else if (tick) begin
                  cnt_reg <= cnt_reg + 21'd1;
               end
            end
            MBW_RT_RUN: begin
               if (trig) begin
                  stage_reg <= 2'd0;
                  cnt_reg   <= '0;
                  if (mode == MBW_MODE_ONCE) begin
                     st_reg <= MBW_RT_DONE;
                  end
               end else if (stg_exp) begin
                  cnt_reg <= '0;
                  unique case (ev_eff)
                     MBW_EV_ACPI: begin
                        act_reg.acpi_overtemp <= ~rt_cfg_reg[RT_ACPI_BIT];
                        act_reg.acpi_fatal    <= rt_cfg_reg[RT_ACPI_BIT];
                     end
                     MBW_EV_RESET: act_reg.sys_reset  <= 1'b1;
                     MBW_EV_PWRB:  act_reg.pwr_button <= 1'b1;
                     default: ;
                  endcase
                  if (has_next) begin
                     stage_reg <= nxt_stage;
                  end else if (mode != MBW_MODE_REPEAT) begin
                     st_reg <= MBW_RT_DONE;
                  end
                  // repeat mode stays on the last stage
               end else if (tick) begin
                  cnt_reg <= cnt_reg + 21'd1;
               end
            end
            MBW_RT_DONE: ;
            default: st_reg <= MBW_RT_IDLE;
         endcase
      end
   end

   assign action_o = act_reg;
endmodule
`default_nettype wire

// ### tb/mbw_props.sv
// assertions on the watchdog top-level ports
`timescale 1ns/1ps
`default_nettype none
module mbw_props
   import mbw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input wire logic                 clk_i,
   input wire logic                 rstn_i,
   // register bus
   input wire logic                 s_awvalid_i,
   input wire logic                 s_awready_o,
   input wire logic [7:0]           s_awaddr_i,
   input wire logic                 s_wvalid_i,
   input wire logic                 s_wready_o,
   input wire logic [3:0]           s_wstrb_i,
   input wire logic                 s_bvalid_o,
   input wire logic                 s_bready_i,
   input wire logic [1:0]           s_bresp_o,
   input wire logic                 s_arvalid_i,
   input wire logic                 s_arready_o,
   input wire logic                 s_rvalid_o,
   input wire logic                 s_rready_i,
   input wire logic [31:0]          s_rdata_o,
   // actions
   input wire mbw_pkg::mbw_action_s action_o
);
   import mbw_pkg::*;
   localparam int QMAX = 1000 * TICK_CYCLES;
   logic [31:0] quiet_reg;
   wire         trig_hit;
   assign trig_hit = s_awvalid_i && s_awready_o && s_wvalid_i
                     && s_wready_o && s_wstrb_i[0]
                     && (s_awaddr_i == OFS_TRIGGER);
   // saturates, so a long idle run never wraps into a false alarm
   always_ff @(posedge clk_i) begin
      if (!rstn_i) quiet_reg <= 32'(QMAX);
      else if (trig_hit) quiet_reg <= 32'h0;
      else if (quiet_reg < 32'(QMAX)) quiet_reg <= quiet_reg + 32'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   AST_RST_IDLE: assert property (disable iff (1'b0)
      !rstn_i |=> action_o == '0 && !s_bvalid_o && !s_rvalid_o)
      else $error("outputs not idle after reset");
   AST_PULSE_ONE: assert property (
      action_o != '0 |=> action_o == '0)
      else $error("action held for more than one cycle");
   AST_ONE_KIND: assert property (
      $onehot0(action_o)) else $error("two actions at once");
   AST_TRIG_QUIET: assert property (
      action_o != '0 |-> quiet_reg >= 32'(QMAX - 4 - TICK_CYCLES))
      else $error("action too soon after retrigger");
   AST_B_TIME: assert property (
      s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
      |-> ##2 s_bvalid_o) else $error("write response late");
   AST_B_HOLD: assert property (
      s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
      else $error("write response dropped");
   AST_R_TIME: assert property (
      s_arvalid_i && s_arready_o |=> s_rvalid_o)
      else $error("read data late");
   AST_R_HOLD: assert property (
      s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
      else $error("read data dropped");
   AST_AR_BLOCK: assert property (
      s_rvalid_o |-> !s_arready_o) else $error("read accepted early");
endmodule
`default_nettype wire

// ### tb/mbw_host.sv
// host firmware model: register accesses over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module mbw_host (
   // clock
   input  wire logic        clk_i,
   // write channels
   output logic             awvalid_o,
   input  wire logic        awready_i,
   output logic [7:0]       awaddr_o,
   output logic             wvalid_o,
   input  wire logic        wready_i,
   output logic [31:0]      wdata_o,
   output logic [3:0]       wstrb_o,
   input  wire logic        bvalid_i,
   output logic             bready_o,
   input  wire logic [1:0]  bresp_i,
   // read channels
   output logic             arvalid_o,
   input  wire logic        arready_i,
   output logic [7:0]       araddr_o,
   input  wire logic        rvalid_i,
   output logic             rready_o,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i
);
   initial begin
      awvalid_o = 1'b0;
      awaddr_o = 8'h0;
      wvalid_o = 1'b0;
      wdata_o = 32'h0;
      wstrb_o = 4'h0;
      bready_o = 1'b0;
      arvalid_o = 1'b0;
      araddr_o = 8'h0;
      rready_o = 1'b0;
   end
   // released payload is inverted so stale values cannot look valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_i);
      awvalid_o <= 1'b1;
      awaddr_o <= a;
      wvalid_o <= 1'b1;
      wdata_o <= d;
      wstrb_o <= 4'hF;
      bready_o <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awvalid_o && awready_i) begin
            awvalid_o <= 1'b0;
            awaddr_o <= ~a;
         end
         if (wvalid_o && wready_i) begin
            wvalid_o <= 1'b0;
            wdata_o <= ~d;
         end
      end while (!bvalid_i);
      bready_o <= 1'b0;
      r = bresp_i;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_i);
      arvalid_o <= 1'b1;
      araddr_o <= a;
      rready_o <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arvalid_o && arready_i) begin
            arvalid_o <= 1'b0;
            araddr_o <= ~a;
         end
      end while (!rvalid_i);
      rready_o <= 1'b0;
      d = rdata_i;
      r = rresp_i;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the boot and runtime watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
   failures++; $display("wrong value %s expected %0h seen %0h", \
   nm, e, s); end end
module tb_top;
   import mbw_pkg::*;
   // one tick per cycle keeps the 30 s boot case inside the run
   localparam int unsigned TICK_CYCLES = 1;
   localparam int LIMIT = 80000;
   logic        clk_i;
   logic        rstn_i = 1'b0;
   logic        ce = 1'b1;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rr;
   mbw_action_s act, act_last;
   int          failures, n_tests, cyc, act_cyc, n_act;
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   mbw_top #(.TICK_CYCLES(TICK_CYCLES)) u_mbw_top (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
      .s_awvalid_i(awvalid), .s_awready_o(awready), .s_awaddr_i(awaddr),
      .s_wvalid_i(wvalid), .s_wready_o(wready), .s_wdata_i(wdata),
      .s_wstrb_i(wstrb), .s_bvalid_o(bvalid), .s_bready_i(bready),
      .s_bresp_o(bresp), .s_arvalid_i(arvalid), .s_arready_o(arready),
      .s_araddr_i(araddr), .s_rvalid_o(rvalid), .s_rready_i(rready),
      .s_rdata_o(rdata), .s_rresp_o(rresp), .action_o(act));
   mbw_host u_host (
      .clk_i(clk_i), .awvalid_o(awvalid), .awready_i(awready),
      .awaddr_o(awaddr), .wvalid_o(wvalid), .wready_i(wready),
      .wdata_o(wdata), .wstrb_o(wstrb), .bvalid_i(bvalid),
      .bready_o(bready), .bresp_i(bresp), .arvalid_o(arvalid),
      .arready_i(arready), .araddr_o(araddr), .rvalid_i(rvalid),
      .rready_o(rready), .rdata_i(rdata), .rresp_i(rresp));
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (act != '0) begin
         act_last <= act;
         act_cyc <= cyc;
         n_act <= n_act + 1;
      end
      if (cyc == LIMIT) begin
         failures++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      u_host.wr(a, d, rr);
      `CHK("bresp", RESP_OKAY, rr)
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      u_host.rd(a, rv, rr);
      `CHK("rresp", er, rr)
      `CHK("rdata", e, rv)
   endtask
   task automatic st_chk(input logic [2:0] e);
      u_host.rd(OFS_STATUS, rv, rr);
      `CHK("state", e, rv[6:4])
   endtask
   task automatic quiet(input int n);
      int k;
      k = n_act;
      repeat (n) @(posedge clk_i);
      `CHK("action count", k, n_act)
   endtask
   task automatic expect_act(input logic [3:0] e, input int lo, input int hi);
      int t0;
      int k;
      t0 = cyc;
      k = n_act;
      while (n_act == k && cyc - t0 <= hi) @(posedge clk_i);
      `CHK("action", e, act_last)
      `CHK("action time", 1'b1, (act_cyc - t0 >= lo && act_cyc - t0 <= hi))
   endtask
   initial begin
      do_reset();
      rreg(OFS_BOOT_CFG, RST_BOOT_CFG, RESP_OKAY);
      rreg(OFS_STG_CFG, RST_STG_CFG, RESP_OKAY);
      rreg(OFS_STATUS, 32'h0, RESP_OKAY);
      rreg(8'h20, 32'h0, RESP_SLVERR);
      u_host.wr(8'h24, 32'hFFFF_FFFF, rr);
      `CHK("unmapped bresp", RESP_SLVERR, rr)
      wreg(OFS_CONTROL, 32'h0000_0004);
      st_chk(3'h0);
      wreg(OFS_BOOT_CFG, 32'h0000_0011);
      wreg(OFS_CONTROL, 32'h0000_0003);
      quiet(500);
      wreg(OFS_CONTROL, 32'h0000_0001);
      expect_act(4'h8, 29990, 30010);
      do_reset();
      rreg(OFS_STATUS, 32'h0, RESP_OKAY);
      wreg(OFS_STG_CFG, 32'h0030_2110);
      wreg(OFS_RT_CFG, 32'h0000_0002);
      wreg(OFS_CONTROL, 32'h0000_0004);
      expect_act(4'h2, 992, 1008);
      expect_act(4'h8, 1992, 2008);
      expect_act(4'h4, 992, 1008);
      quiet(2500);
      st_chk(3'h3);
      do_reset();
      rreg(OFS_STATUS, 32'h0, RESP_OKAY);
      wreg(OFS_STG_CFG, 32'h0000_0010);
      wreg(OFS_RT_CFG, 32'h0000_0113);
      wreg(OFS_CONTROL, 32'h0000_0004);
      expect_act(4'h1, 10992, 11008);
      quiet(600);
      wreg(OFS_TRIGGER, 32'h0);
      quiet(600);
      wreg(OFS_TRIGGER, 32'h0);
      expect_act(4'h1, 992, 1008);
      expect_act(4'h1, 992, 1008);
      do_reset();
      wreg(OFS_RT_CFG, 32'h0000_0001);
      wreg(OFS_CONTROL, 32'h0000_0004);
      ce <= 1'b0;
      quiet(2500);
      ce <= 1'b1;
      quiet(500);
      wreg(OFS_TRIGGER, 32'h0);
      quiet(3000);
      st_chk(3'h3);
      give_verdict();
   end
endmodule
bind mbw_top mbw_props #(.TICK_CYCLES(TICK_CYCLES)) u_mbw_props (
   .clk_i(clk_i), .rstn_i(rstn_i), .s_awvalid_i(s_awvalid_i),
   .s_awready_o(s_awready_o), .s_awaddr_i(s_awaddr_i),
   .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o),
   .s_wstrb_i(s_wstrb_i), .s_bvalid_o(s_bvalid_o),
   .s_bready_i(s_bready_i), .s_bresp_o(s_bresp_o),
   .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o),
   .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i),
   .s_rdata_o(s_rdata_o), .action_o(action_o));
`default_nettype wire
